// ===== inc/pwrsw_map.vh
`ifndef PWRSW_MAP_VH
`define PWRSW_MAP_VH
// register addresses on the special function register bus
`define PWRSW_ADDR_KEY      8'hC1
`define PWRSW_ADDR_PWRCTL   8'hC5
`define PWRSW_ADDR_IRQEN    8'hEC
`define PWRSW_ADDR_PERCFG   8'hF4
`define PWRSW_ADDR_SWCFG    8'hF5
`define PWRSW_ADDR_IRQFLAG  8'hF8
`define PWRSW_ADDR_PINCFG   8'hFF
// unlock value for the write key register
`define PWRSW_KEY_VALUE     8'hA7
// power control register fields
`define PWRSW_PC_METER_BIT  6
`define PWRSW_PC_HALT_BIT   4
`define PWRSW_PC_DIV_MSB    2
`define PWRSW_PC_DIV_LSB    0
`define PWRSW_PC_DIV_RST    3'h2
// writable power control bits; reserved 7, 5 and 3 stay zero
`define PWRSW_PC_WR_MASK    8'h57
// switchover config and status fields
`define PWRSW_SEL_RST       2'h0
`define PWRSW_SEL_VDD       2'h0
`define PWRSW_SEL_VDD_DCIN  2'h1
`define PWRSW_SEL_OFF_BIT   1
`define PWRSW_SRC_BIT       6
`define PWRSW_FLAG_SWO_BIT  1
`define PWRSW_FLAG_RST_BIT  7
`define PWRSW_PIN_MSB       4
`define PWRSW_PIN_LSB       2
`define PWRSW_PIN_FORCE     2'h1
// core clock generation, rates in kHz
`define PWRSW_SYS_KHZ       50000
`define PWRSW_BASE_KHZ      4096
`endif

// ===== rtl/pwrsw_clkdiv.v
`timescale 1ns/1ps
`include "pwrsw_map.vh"
module pwrsw_clkdiv #(
  parameter SYS_KHZ  = `PWRSW_SYS_KHZ,
  parameter BASE_KHZ = `PWRSW_BASE_KHZ
) (
  input  wire       core_clk_i,
  input  wire       rstn_i,
  input  wire [2:0] div_sel_i,
  output reg        core_en_o
);
  reg  [16:0] acc_r;
  reg  [6:0]  cnt_r;
  wire [17:0] acc_sum = {1'b0, acc_r} + BASE_KHZ[17:0];
  wire        base_tick = (acc_sum >= SYS_KHZ[17:0]);
  wire [6:0]  div_mask = (7'h01 << div_sel_i) - 7'h01;

  // fractional accumulator: average base tick rate is exact, jitter of one cycle
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      acc_r     <= 17'h0_0000;
      cnt_r     <= 7'h00;
      core_en_o <= 1'b0;
    end else begin
      acc_r     <= base_tick ? acc_sum[16:0] - SYS_KHZ[16:0] : acc_sum[16:0];
      core_en_o <= 1'b0;
      if (base_tick) begin
        cnt_r <= (cnt_r & div_mask) == div_mask ? 7'h00 : cnt_r + 7'h01;
        if ((cnt_r & div_mask) == div_mask)
          core_en_o <= 1'b1;
      end
    end
  end
endmodule // pwrsw_clkdiv

// ===== rtl/pwrsw_top.v
`timescale 1ns/1ps
`include "pwrsw_map.vh"
module pwrsw_top (
  input  wire       core_clk_i,
  input  wire       rstn_i,
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire       sfr_rd_i,
  input  wire [7:0] sfr_wdata_i,
  output reg  [7:0] sfr_rdata_o,
  input  wire       vdd_low_i,
  input  wire       dcin_low_i,
  input  wire       battery_force_pin_i,
  output wire       rail_main_o,
  output wire       rail_backup_o,
  output wire       meter_off_o,
  output wire       core_halt_o,
  output wire       core_clk_en_o,
  output wire       supply_irq_o
);
  reg  [7:0] power_control_r;
  reg        key_armed_r;
  reg  [1:0] switchover_select_r;
  reg  [2:0] pin_cfg_r;
  reg        irq_en_swo_r;
  reg        irq_en_rst_r;
  reg        switchover_flag_r;
  reg        supply_restored_flag_r;
  reg        on_backup_r;
  reg        on_backup_nxt;
  reg  [2:0] sync1_r;
  reg  [2:0] sync2_r;
  reg        force_d_r;
  reg  [7:0] rdata_nxt;

  // rail states of the switchover machine
  localparam RAIL_MAIN   = 1'b0;
  localparam RAIL_BACKUP = 1'b1;

  // write strobe decode, shared by every writable register
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  wire       wr_key     = wr_hit(sfr_wr_i, sfr_addr_i, `PWRSW_ADDR_KEY);
  wire       wr_pwr     = wr_hit(sfr_wr_i, sfr_addr_i, `PWRSW_ADDR_PWRCTL);
  wire       wr_flag    = wr_hit(sfr_wr_i, sfr_addr_i, `PWRSW_ADDR_IRQFLAG);
  wire       wr_swcfg   = wr_hit(sfr_wr_i, sfr_addr_i, `PWRSW_ADDR_SWCFG);
  wire       wr_pincfg  = wr_hit(sfr_wr_i, sfr_addr_i, `PWRSW_ADDR_PINCFG);
  wire       wr_irqen   = wr_hit(sfr_wr_i, sfr_addr_i, `PWRSW_ADDR_IRQEN);
  // synchronised comparator levels and force pin
  wire       vdd_low    = sync2_r[0];
  wire       dcin_low   = sync2_r[1];
  wire       force_s    = sync2_r[2];
  // force pin counts only when its pin config selects it
  wire       force_en   = (pin_cfg_r[1:0] == `PWRSW_PIN_FORCE);
  wire       force_rise = force_en && force_s && !force_d_r;
  wire       swo_off    = switchover_select_r[`PWRSW_SEL_OFF_BIT];
  // select 00 main low only, 01 adds dc sense
  wire       level_trig = vdd_low || (dcin_low && (switchover_select_r == `PWRSW_SEL_VDD_DCIN));
  // rail transitions, used to latch the event flags
  wire       enter_bkp  = !on_backup_r && on_backup_nxt;
  wire       leave_bkp  = on_backup_r && !on_backup_nxt;
  // interrupt sources, each gated by its own enable
  wire       irq_swo    = switchover_flag_r && irq_en_swo_r;
  wire       irq_rst    = supply_restored_flag_r && irq_en_rst_r;

  // sync inputs: first stage feeds only the second stage
  // limitation: pin pulses shorter than one clock may never be seen
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sync1_r   <= 3'h0;
      sync2_r   <= 3'h0;
      force_d_r <= 1'b0;
    end else begin
      sync1_r   <= {battery_force_pin_i, dcin_low_i, vdd_low_i};
      sync2_r   <= sync1_r;
      force_d_r <= sync2_r[2];
    end
  end

  // switchover decision; dc sense only enters as a level
  always @* begin
    on_backup_nxt = on_backup_r;
    case (on_backup_r)
      // force edge switches from main regardless of levels
      RAIL_MAIN: begin
        on_backup_nxt = level_trig || force_rise;
      end
      // stay on backup while any enabled trigger holds
      RAIL_BACKUP: begin
        on_backup_nxt = level_trig || (force_en && force_s);
      end
      default: begin
        on_backup_nxt = RAIL_MAIN;
      end
    endcase
    // disabled select pins the rail on main, overriding all triggers
    if (swo_off)
      on_backup_nxt = RAIL_MAIN;
  end

  // reset leaves automatic switchover armed with select 00
  always @(posedge core_clk_i) begin
    if (!rstn_i)
      on_backup_r <= 1'b0;
    else
      on_backup_r <= on_backup_nxt;
  end

  // one-hot rail select; no core reset on switching
  assign rail_main_o   = !on_backup_r;
  assign rail_backup_o = on_backup_r;
  // meter shutdown bit; forced off on backup
  assign meter_off_o   = power_control_r[`PWRSW_PC_METER_BIT] || on_backup_r;
  // halt only in battery run state
  assign core_halt_o   = power_control_r[`PWRSW_PC_HALT_BIT] && on_backup_r;
  // flags gated by enables onto one request line
  assign supply_irq_o  = irq_swo || irq_rst;

  // register writes, key sequencing and sticky flags
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      // reserved bits zero; divider resets to 010
      power_control_r        <= {5'h00, `PWRSW_PC_DIV_RST};
      key_armed_r            <= 1'b0;
      switchover_select_r    <= `PWRSW_SEL_RST;
      pin_cfg_r              <= 3'h0;
      irq_en_swo_r           <= 1'b0;
      irq_en_rst_r           <= 1'b0;
      switchover_flag_r      <= 1'b0;
      supply_restored_flag_r <= 1'b0;
    end else begin
      // any access other than the key write disarms
      if (sfr_wr_i || sfr_rd_i)
        key_armed_r <= wr_key && (sfr_wdata_i == `PWRSW_KEY_VALUE);
      // keyed write; reserved bits masked off
      if (wr_pwr && key_armed_r)
        power_control_r <= sfr_wdata_i & `PWRSW_PC_WR_MASK;
      // plain config writes need no key
      if (wr_swcfg)
        switchover_select_r <= sfr_wdata_i[1:0];
      if (wr_pincfg)
        pin_cfg_r <= sfr_wdata_i[`PWRSW_PIN_MSB:`PWRSW_PIN_LSB];
      if (wr_irqen) begin
        irq_en_swo_r <= sfr_wdata_i[`PWRSW_FLAG_SWO_BIT];
        irq_en_rst_r <= sfr_wdata_i[`PWRSW_FLAG_RST_BIT];
      end
      // latch regardless of enable; set beats a write of 0
      if (enter_bkp)
        switchover_flag_r <= 1'b1;
      else if (wr_flag && !sfr_wdata_i[`PWRSW_FLAG_SWO_BIT])
        switchover_flag_r <= 1'b0;
      if (leave_bkp)
        supply_restored_flag_r <= 1'b1;
      else if (wr_flag && !sfr_wdata_i[`PWRSW_FLAG_RST_BIT])
        supply_restored_flag_r <= 1'b0;
    end
  end

  // read mux; key register is write only and reads zero
  // reads only disarm the key and leave the flags alone, so polling the flags is safe
  always @* begin
    rdata_nxt = 8'h00;
    case (sfr_addr_i)
      `PWRSW_ADDR_PWRCTL:  rdata_nxt = power_control_r;
      `PWRSW_ADDR_SWCFG:   rdata_nxt = {6'h00, switchover_select_r};
      `PWRSW_ADDR_PINCFG:  rdata_nxt = {3'h0, pin_cfg_r, 2'h0};
      `PWRSW_ADDR_IRQEN:   rdata_nxt = {irq_en_rst_r, 5'h00, irq_en_swo_r, 1'b0};
      `PWRSW_ADDR_IRQFLAG: rdata_nxt = {supply_restored_flag_r, 5'h00, switchover_flag_r, 1'b0};
      `PWRSW_ADDR_PERCFG:  rdata_nxt = {1'b0, !on_backup_r, 6'h00};
      default:             rdata_nxt = 8'h00;
    endcase
  end

  // read data registered, held until the next read
  always @(posedge core_clk_i) begin
    if (!rstn_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
      sfr_rdata_o <= rdata_nxt;
  end

  // core clock enable from the programmed divider
  pwrsw_clkdiv u_clkdiv (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .div_sel_i  (power_control_r[`PWRSW_PC_DIV_MSB:`PWRSW_PC_DIV_LSB]),
    .core_en_o  (core_clk_en_o)
  );
endmodule // pwrsw_top

// ===== tb/pwrsw_chk_sva.sv
`timescale 1ns/1ps
module pwrsw_chk (
  input wire       core_clk_i,
  input wire       rstn_i,
  input wire [7:0] sfr_addr_i,
  input wire       sfr_wr_i,
  input wire       sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire       vdd_low_i,
  input wire       dcin_low_i,
  input wire       battery_force_pin_i,
  input wire       rail_main_o,
  input wire       rail_backup_o,
  input wire       meter_off_o,
  input wire       core_halt_o,
  input wire       core_clk_en_o,
  input wire       supply_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  reg       armed_r;
  reg       keyed_r;
  reg [3:0] trig_r;
  // key tracking and trigger history, sized to cover the sync latency
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      armed_r <= 1'b0;
      keyed_r <= 1'b0;
      trig_r  <= 4'h0;
    end else begin
      if (sfr_wr_i | sfr_rd_i) armed_r <= sfr_wr_i & (sfr_addr_i == 8'hc1) & (sfr_wdata_i == 8'ha7);
      keyed_r <= armed_r & sfr_wr_i & (sfr_addr_i == 8'hc5);
      trig_r  <= {trig_r[2:0], vdd_low_i | dcin_low_i | battery_force_pin_i};
    end
  end
  rail_onehot_a: assert property (rail_main_o ^ rail_backup_o)
    else $error("rail select not one-hot");
  meter_backup_a: assert property (rail_backup_o |-> meter_off_o)
    else $error("metering on while on backup");
  halt_backup_a: assert property (core_halt_o |-> rail_backup_o)
    else $error("halt outside backup run");
  clk_pulse_a: assert property (core_clk_en_o |=> !core_clk_en_o)
    else $error("clock enable too wide");
  switch_cause_a: assert property ($rose(rail_backup_o) |-> |trig_r)
    else $error("switchover without trigger");
  irq_cause_a: assert property ($rose(supply_irq_o) |-> $past(sfr_wr_i) || $changed(rail_main_o))
    else $error("irq without event");
  rdata_hold_a: assert property ($changed(sfr_rdata_o) |-> $past(sfr_rd_i))
    else $error("read data moved without read");
  keyed_write_a: assert property ($rose(meter_off_o) && rail_main_o |-> keyed_r)
    else $error("power control changed without key");
  cover property ($rose(rail_backup_o));
  cover property ($fell(rail_backup_o));
  cover property ($rose(meter_off_o) && rail_main_o);
endmodule // pwrsw_chk
bind pwrsw_top pwrsw_chk u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
  .vdd_low_i(vdd_low_i), .dcin_low_i(dcin_low_i), .battery_force_pin_i(battery_force_pin_i),
  .rail_main_o(rail_main_o), .rail_backup_o(rail_backup_o), .meter_off_o(meter_off_o),
  .core_halt_o(core_halt_o), .core_clk_en_o(core_clk_en_o), .supply_irq_o(supply_irq_o));

// ===== tb/pwrsw_core_model.sv
`timescale 1ns/1ps
module pwrsw_core_model (
  input  wire       core_clk_i,
  input  wire [7:0] sfr_rdata_i,
  output reg  [7:0] sfr_addr_o = 8'h00,
  output reg        sfr_wr_o = 1'b0,
  output reg        sfr_rd_o = 1'b0,
  output reg  [7:0] sfr_wdata_o = 8'h00
);
  // one-cycle strobes set and dropped on falling edges
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge core_clk_i) sfr_addr_o = a;
      sfr_wdata_o = d;
      sfr_wr_o = 1'b1;
      @(negedge core_clk_i) sfr_wr_o = 1'b0;
      sfr_wdata_o = ~d; // released data is not left looking valid
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge core_clk_i) sfr_addr_o = a;
      sfr_rd_o = 1'b1;
      @(negedge core_clk_i) sfr_rd_o = 1'b0;
      d = sfr_rdata_i;
    end
  endtask
  task kw(input [7:0] d);
    begin
      wr(8'hc1, 8'ha7);
      wr(8'hc5, d);
    end
  endtask
endmodule // pwrsw_core_model

// ===== tb/pwrsw_top_tb.sv
`timescale 1ns/1ps
module pwrsw_top_tb;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         vdd = 1'b0;
  reg         dc = 1'b0;
  reg         fp = 1'b0;
  reg  [31:0] seed = 32'hf6d8_c4f4;
  reg  [7:0]  rv;
  wire [7:0]  addr, wdata, rdata;
  wire        wr, rd, r_main, r_bak, m_off, halt, clk_en, irq;
  wire [7:0]  st = {3'h0, r_main, r_bak, m_off, halt, irq};
  integer     failures = 0;
  integer     n_compared = 0;
  integer     cnt, d, e;
  always #10 clk = ~clk;
  pwrsw_top DUT (.core_clk_i(clk), .rstn_i(rstn), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .vdd_low_i(vdd), .dcin_low_i(dc), .battery_force_pin_i(fp),
    .rail_main_o(r_main), .rail_backup_o(r_bak), .meter_off_o(m_off), .core_halt_o(halt),
    .core_clk_en_o(clk_en), .supply_irq_o(irq));
  pwrsw_core_model core (.core_clk_i(clk), .sfr_rdata_i(rdata), .sfr_addr_o(addr), .sfr_wr_o(wr),
    .sfr_rd_o(rd), .sfr_wdata_o(wdata));
  // outputs expected with halt bit set: b backup, m meter bit, i irq
  function [7:0] xs(input b, input m, input i);
    xs = {3'h0, ~b, b, m | b, b, i};
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: 0x%h vs 0x%h", $time, seen, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [7:0] x);
    begin
      core.rd(a, rv);
      check(rv, x);
    end
  endtask
  // levels move on falling edge, then wait out the sync chain
  task lv(input v, input c, input f);
    begin
      @(negedge clk) vdd = v;
      dc = c;
      fp = f;
      repeat (6) @(negedge clk);
    end
  endtask
  task report_and_stop;
    begin
      if (failures == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // watchdog: run needs about 50k cycles, give up at 75k
  initial begin
    #1_500_000;
    failures = failures + 1;
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    rchk(8'hc5, 8'h02);
    rchk(8'hf4, 8'h40);
    rchk(8'hf5, 8'h00);
    repeat (4) begin
      rv = $random(seed);
      core.wr(8'hc5, rv);
    end
    core.wr(8'hc1, 8'ha7);
    core.rd(8'hf4, rv);
    core.wr(8'hc5, 8'h50);
    rchk(8'hc5, 8'h02);
    core.kw(8'hff);
    rchk(8'hc5, 8'h57);
    check(st, xs(0, 1, 0));
    // every divider code; 6250 cycles hold 512 base periods
    for (d = 0; d < 8; d = d + 1) begin
      core.kw(d[7:0]);
      cnt = 0;
      repeat (6250) @(negedge clk) cnt = cnt + clk_en;
      e = 512 >> d;
      check({7'h00, cnt >= e - 1 && cnt <= e + 1}, 8'h01);
    end
    core.kw(8'h12);
    lv(1, 0, 0);
    check(st, xs(1, 0, 0));
    rchk(8'hc5, 8'h12);
    rchk(8'hf4, 8'h00);
    rchk(8'hf8, 8'h02);
    core.wr(8'hec, 8'h82);
    check(st, xs(1, 0, 1));
    lv(0, 0, 0);
    rchk(8'hf8, 8'h82);
    core.wr(8'hec, 8'h00);
    core.wr(8'hf8, 8'h00);
    rchk(8'hf8, 8'h00);
    lv(0, 0, 1);
    check(st, xs(0, 0, 0));
    lv(0, 1, 0);
    check(st, xs(0, 0, 0));
    core.wr(8'hf5, 8'h01);
    lv(0, 1, 0);
    check(st, xs(1, 0, 0));
    core.wr(8'hf5, 8'h02);
    lv(1, 1, 0);
    check(st, xs(0, 0, 0));
    lv(0, 0, 0);
    core.wr(8'hf5, 8'h00);
    core.wr(8'hff, 8'h04);
    lv(0, 0, 1);
    check(st, xs(1, 0, 0));
    lv(1, 0, 0);
    check(st, xs(1, 0, 0));
    lv(0, 0, 0);
    check(st, xs(0, 0, 0));
    report_and_stop;
  end
endmodule // pwrsw_top_tb
